/* include/cpsc_pkg.sv */
// Package of the clock prescaler and sleep controller: offsets, fields,
// reset values, timing counts, state codes and carrier structs.
// Assumes one 20 MHz source clock; all counts are in cycles of it.
package cpsc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register offsets on the plain register port
    localparam logic [3:0] CLKDIV_OFFSET = 4'h0;
    localparam logic [3:0] SLEEP_OFFSET  = 4'h1;

    ////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int UNLOCK_BIT   = 7;
    localparam int CODE_LSB     = 0;
    localparam int CODE_W       = 4;
    localparam int SLEEP_EN_BIT = 0;
    localparam int MODE_LSB     = 1;
    localparam int MODE_W       = 3;

    ////////////////////////////////////////////////////////////////////////
    // Values and reset values
    localparam logic [7:0] UNLOCK_PATTERN   = 8'h80;
    localparam logic [3:0] CODE_RESET_PLAIN = 4'h0;
    localparam logic [3:0] CODE_RESET_DIV8  = 4'h3;
    localparam logic [3:0] CODE_MAX         = 4'h8;
    localparam logic [7:0] SLEEP_REG_RESET  = 8'h00;
    localparam logic [2:0] MODE_IDLE        = 3'h0;
    localparam logic [2:0] MODE_ADCNR       = 3'h1;
    localparam logic [2:0] MODE_PDOWN       = 3'h2;
    localparam logic [2:0] MODE_STANDBY     = 3'h6;

    ////////////////////////////////////////////////////////////////////////
    // Timing counts, in source clock cycles
    localparam int UNLOCK_WINDOW_CYC = 4;
    localparam int WAKE_HALT_CYC     = 4;
    localparam int STANDBY_WAKE_CYC  = 6;
    localparam int PDOWN_STARTUP_CYC = 1024;
    localparam int FUSE_SETTLE_CYC   = 2;

    ////////////////////////////////////////////////////////////////////////
    // Sleep sequencer states, one-hot
    typedef enum logic [3:0] {
        ST_RUN   = 4'b0001,
        ST_SLEEP = 4'b0010,
        ST_START = 4'b0100,
        ST_HALT  = 4'b1000
    } cpsc_state_type;

    // Clock domain enables
    typedef struct packed {
        logic cpu;
        logic flash;
        logic io;
        logic adc;
    } cpsc_clken_type;

    // Enabled interrupt requests from the peripherals
    typedef struct packed {
        logic timerIrq;
        logic serialIrq;
        logic adcDoneIrq;
        logic memReadyIrq;
        logic watchdogIrq;
        logic pscIrq;
        logic otherIrq;
    } cpsc_irq_type;

endpackage

/* hw/cpsc_sync.sv */
// Two-flop synchroniser for levels arriving from pins.
// Assumes the inputs are quasi-static compared to the source clock.
`timescale 1ns/1ps
module cpsc_sync #(
    parameter int WIDTH = 5
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Levels
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stage1_r;

    ////////////////////////////////////////////////////////////////////////
    // First stage is read only by the second
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stage1_r <= '0;
            syncOut  <= '0;
        end else begin
            stage1_r <= asyncIn;
            syncOut  <= stage1_r;
        end
    end

endmodule // cpsc_sync

/* hw/cpsc_clock_sleep.sv */
// Clock prescaler with protected divider change, and sleep mode sequencer.
// Runs on the undivided source clock; emits per-domain clock enables.
// Assumes the core drives the register port and the sleep instruction pulse.
//
// Behaviour
// RULE1: CPU, flash, I/O and ADC enables tick at the selected division.
// RULE2: Divider change never yields a glitch or a faster intermediate rate.
// RULE3: New rate starts after one old period then one new period, two edges.
// RULE4: Unlock bit sets only when written 1 with all other bits zero.
// RULE5: Software writes the new code within four cycles of unlocking.
// RULE6: Unlock clears four cycles after setting or on a code write.
// RULE7: Rewriting unlock while it runs neither restarts nor clears it.
// RULE8: Software keeps interrupts off across the two-write change.
// RULE9: Code n divides by two to the n, up to 256; above eight reserved.
// RULE10: Reset code is three with startup fuse programmed, else zero.
// RULE11: Any code is accepted through the unlock sequence, fuse regardless.
// RULE12: Sleep entered only on sleep instruction with sleep enable set.
// RULE13: Mode 000 Idle, 001 ADC noise, 010 power-down, 110 standby.
// RULE14: Wake halts four cycles plus startup, then interrupt, then resume.
// RULE15: Register file and SRAM stay unchanged across sleep and wake.
// RULE16: Reset during sleep wakes the device to the reset vector.
// RULE17: Software sets sleep enable just before sleeping, clears after.
// RULE18: Idle stops only CPU and flash clocks; I/O and ADC keep running.
// RULE19: Idle wakes on any enabled internal or external interrupt.
// RULE20: Entering Idle or ADC noise mode with ADC on starts a conversion.
// RULE21: ADC noise mode stops I/O, CPU and flash clocks; ADC runs.
// RULE22: ADC noise mode wakes only on its listed sources.
// RULE23: Power-down halts every clock and the oscillator.
// RULE24: Standby is power-down with oscillator running, wake in six cycles; pscIrq wakes power-down here but not standby.
// RULE25: Startup fuse sampled after reset before the core gets clocks.
//
// Design decisions made here: strobed register access, the placing of the registers, reserved codes and modes, and the pscIrq wake sources.
`timescale 1ns/1ps
module cpsc_clock_sleep (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst,
    // Register port
    input  wire logic [3:0]              regAddr,
    input  wire logic [7:0]              regWdata,
    input  wire logic                    regWr,
    input  wire logic                    regRd,
    output logic      [7:0]              regRdata_r,
    // Strap and pins
    input  wire logic                    startupDivideFuse,
    input  wire logic [3:0]              externalInterruptPins,
    // Core side
    input  wire logic                    sleepInstr,
    input  wire logic                    adcEnabled,
    input  wire cpsc_pkg::cpsc_irq_type  irqReq,
    // Clock control outputs
    output cpsc_pkg::cpsc_clken_type     clkEn_r,
    output logic                         oscRun_r,
    output logic                         coreAsleep_r,
    output logic                         resumeIrq_r,
    output logic                         adcAutoStart_r
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [4:0]               syncIn;
    logic [4:0]               syncOut;
    logic                     fuseSync;
    logic [3:0]               extLevel;
    logic [1:0]               bootCnt_r;
    logic                     booted_r;
    logic [3:0]               code_r;
    logic [3:0]               activeCode_r;
    logic                     switchPend_r;
    logic                     unlock_r;
    logic [2:0]               unlockCnt_r;
    logic [7:0]               divCnt_r;
    logic [3:0]               effCode;
    logic [7:0]               divLimit;
    logic                     divTick;
    logic                     wrDiv;
    logic                     wrSleep;
    logic                     unlockReq;
    logic                     codeWrite;
    logic [2:0]               mode_r;
    logic                     sleepEn_r;
    logic                     modeLegal;
    logic                     goSleep;
    logic [2:0]               sleepMode_r;
    logic                     wakeHit;
    logic [10:0]              waitCnt_r;
    cpsc_pkg::cpsc_state_type state_r;
    cpsc_pkg::cpsc_state_type state_nxt;
    cpsc_pkg::cpsc_clken_type gate;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisation: fuse strap and external level interrupts
    assign syncIn   = {startupDivideFuse, externalInterruptPins};
    assign fuseSync = syncOut[4];
    assign extLevel = syncOut[3:0];

    cpsc_sync #(
        .WIDTH   (5)
    ) u_sync (
        .clk     (clk),
        .rst     (rst),
        .asyncIn (syncIn),
        .syncOut (syncOut)
    );

    ////////////////////////////////////////////////////////////////////////
    // Boot: wait for the synchronised strap before clocking the core
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bootCnt_r <= 2'h0;
            booted_r  <= 1'b0;
        end else if (!booted_r) begin
            if (bootCnt_r == 2'(cpsc_pkg::FUSE_SETTLE_CYC)) begin
                booted_r <= 1'b1; // [RULE25]
            end else begin
                bootCnt_r <= bootCnt_r + 2'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register strobe decode
    assign wrDiv     = regWr && (regAddr == cpsc_pkg::CLKDIV_OFFSET);
    assign wrSleep   = regWr && (regAddr == cpsc_pkg::SLEEP_OFFSET);
    assign unlockReq = wrDiv && (regWdata == cpsc_pkg::UNLOCK_PATTERN); // [RULE4]
    // Code write only inside the unlock window and with unlock written zero
    assign codeWrite = wrDiv && unlock_r && !regWdata[cpsc_pkg::UNLOCK_BIT]; // [RULE11]

    ////////////////////////////////////////////////////////////////////////
    // Unlock bit and its four-cycle window
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            unlock_r    <= 1'b0;
            unlockCnt_r <= 3'h0;
        end else if (codeWrite) begin
            unlock_r <= 1'b0; // [RULE6]
        end else if (unlockReq && !unlock_r) begin
            unlock_r    <= 1'b1; // [RULE4]
            unlockCnt_r <= 3'(cpsc_pkg::UNLOCK_WINDOW_CYC - 1);
        end else if (unlock_r) begin
            // A repeated unlock write lands here: no restart, no clear [RULE7]
            if (unlockCnt_r == 3'h0) begin
                unlock_r <= 1'b0; // [RULE6]
            end else begin
                unlockCnt_r <= unlockCnt_r - 3'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Divider code: strap load at boot, protected write, deferred switch
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            code_r       <= cpsc_pkg::CODE_RESET_PLAIN;
            activeCode_r <= cpsc_pkg::CODE_RESET_PLAIN;
            switchPend_r <= 1'b0;
        end else if (!booted_r) begin
            // Strap is caught after release, never under the reset itself
            if (bootCnt_r == 2'(cpsc_pkg::FUSE_SETTLE_CYC)) begin
                code_r       <= fuseSync ? cpsc_pkg::CODE_RESET_DIV8
                                         : cpsc_pkg::CODE_RESET_PLAIN; // [RULE10]
                activeCode_r <= fuseSync ? cpsc_pkg::CODE_RESET_DIV8
                                         : cpsc_pkg::CODE_RESET_PLAIN; // [RULE25]
            end
        end else begin
            if (codeWrite) begin
                code_r <= regWdata[cpsc_pkg::CODE_LSB +: cpsc_pkg::CODE_W]; // [RULE11]
            end
            // Switch only on an old-rate tick so no short period appears
            if (divTick && switchPend_r) begin
                activeCode_r <= code_r; // [RULE2]
            end
            if (codeWrite) begin
                switchPend_r <= 1'b1;
            end else if (divTick) begin
                switchPend_r <= 1'b0; // [RULE3]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Division factor: reserved codes saturate at the largest factor
    assign effCode  = (activeCode_r > cpsc_pkg::CODE_MAX) ? cpsc_pkg::CODE_MAX
                                                          : activeCode_r;
    assign divLimit = 8'((16'h1 << effCode) - 16'h1); // [RULE9]
    assign divTick  = (divCnt_r == divLimit);

    // Phase counter restarts on every tick, so the first new period is whole
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            divCnt_r <= 8'h00;
        end else if (divTick) begin
            divCnt_r <= 8'h00; // [RULE3]
        end else begin
            divCnt_r <= divCnt_r + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sleep mode control register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_r    <= cpsc_pkg::SLEEP_REG_RESET[cpsc_pkg::MODE_LSB +: cpsc_pkg::MODE_W];
            sleepEn_r <= cpsc_pkg::SLEEP_REG_RESET[cpsc_pkg::SLEEP_EN_BIT];
        end else if (wrSleep) begin
            mode_r    <= regWdata[cpsc_pkg::MODE_LSB +: cpsc_pkg::MODE_W];
            sleepEn_r <= regWdata[cpsc_pkg::SLEEP_EN_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data, valid only in the cycle after the read strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            regRdata_r <= 8'h00;
        end else if (regRd && regAddr == cpsc_pkg::CLKDIV_OFFSET) begin
            regRdata_r <= {unlock_r, 3'h0, code_r};
        end else if (regRd && regAddr == cpsc_pkg::SLEEP_OFFSET) begin
            regRdata_r <= {4'h0, mode_r, sleepEn_r};
        end else begin
            regRdata_r <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sleep entry: reserved mode codes are ignored rather than guessed at
    assign modeLegal = (mode_r == cpsc_pkg::MODE_IDLE)
                    || (mode_r == cpsc_pkg::MODE_ADCNR)
                    || (mode_r == cpsc_pkg::MODE_PDOWN)
                    || (mode_r == cpsc_pkg::MODE_STANDBY); // [RULE13]
    assign goSleep   = (state_r == cpsc_pkg::ST_RUN) && booted_r && sleepInstr
                    && sleepEn_r && modeLegal; // [RULE12]

    // Wake sources per mode; pin interrupts count as level only
    always_comb begin
        wakeHit = 1'b0;
        unique case (sleepMode_r)
            cpsc_pkg::MODE_IDLE: begin
                wakeHit = (|irqReq) || (|extLevel); // [RULE19]
            end
            cpsc_pkg::MODE_ADCNR: begin
                wakeHit = irqReq.adcDoneIrq || irqReq.timerIrq
                       || irqReq.memReadyIrq || irqReq.watchdogIrq
                       || irqReq.pscIrq || (|extLevel); // [RULE22]
            end
            cpsc_pkg::MODE_PDOWN: begin
                wakeHit = irqReq.watchdogIrq || irqReq.pscIrq
                       || (|extLevel); // [RULE23]
            end
            default: begin
                // Standby: no peripheral clock, so only pins and watchdog
                wakeHit = irqReq.watchdogIrq || (|extLevel); // [RULE24]
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer next state
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            cpsc_pkg::ST_RUN: begin
                if (goSleep) begin
                    state_nxt = cpsc_pkg::ST_SLEEP;
                end
            end
            cpsc_pkg::ST_SLEEP: begin
                if (wakeHit) begin
                    state_nxt = cpsc_pkg::ST_START;
                end
            end
            cpsc_pkg::ST_START: begin
                if (waitCnt_r == 11'h000) begin
                    state_nxt = cpsc_pkg::ST_HALT;
                end
            end
            cpsc_pkg::ST_HALT: begin
                if (waitCnt_r == 11'h000) begin
                    state_nxt = cpsc_pkg::ST_RUN;
                end
            end
            default: begin
                state_nxt = cpsc_pkg::ST_RUN;
            end
        endcase
    end

    // Reset from any state returns the core to the reset vector
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= cpsc_pkg::ST_RUN; // [RULE16]
        end else begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Latched mode and wake wait counter
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sleepMode_r <= cpsc_pkg::MODE_IDLE;
            waitCnt_r   <= 11'h000;
        end else if (goSleep) begin
            sleepMode_r <= mode_r;
        end else if (state_r == cpsc_pkg::ST_SLEEP && wakeHit) begin
            // Oscillator restart time depends on what was stopped
            if (sleepMode_r == cpsc_pkg::MODE_PDOWN) begin
                waitCnt_r <= 11'(cpsc_pkg::PDOWN_STARTUP_CYC - 1); // [RULE23]
            end else if (sleepMode_r == cpsc_pkg::MODE_STANDBY) begin
                waitCnt_r <= 11'(cpsc_pkg::STANDBY_WAKE_CYC - 1); // [RULE24]
            end else begin
                waitCnt_r <= 11'h000;
            end
        end else if (state_r == cpsc_pkg::ST_START && waitCnt_r == 11'h000) begin
            waitCnt_r <= 11'(cpsc_pkg::WAKE_HALT_CYC - 1); // [RULE14]
        end else if (waitCnt_r != 11'h000) begin
            waitCnt_r <= waitCnt_r - 11'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Domain gating per state and mode
    always_comb begin
        gate = '0;
        unique case (state_r)
            cpsc_pkg::ST_RUN: begin
                gate = booted_r ? 4'hf : 4'h0; // [RULE25]
            end
            cpsc_pkg::ST_HALT: begin
                gate.io  = 1'b1;
                gate.adc = 1'b1;
            end
            default: begin
                if (sleepMode_r == cpsc_pkg::MODE_IDLE) begin
                    gate.io  = 1'b1; // [RULE18]
                    gate.adc = 1'b1;
                end else if (sleepMode_r == cpsc_pkg::MODE_ADCNR) begin
                    gate.adc = 1'b1; // [RULE21]
                end
            end
        endcase
    end

    // Enables pulse on each divided tick; gating only drops whole pulses
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clkEn_r <= '0;
        end else begin
            clkEn_r <= divTick ? gate : '0; // [RULE1]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status outputs to the core and the oscillator
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            oscRun_r       <= 1'b1;
            coreAsleep_r   <= 1'b0;
            resumeIrq_r    <= 1'b0;
            adcAutoStart_r <= 1'b0;
        end else begin
            oscRun_r       <= !(state_r == cpsc_pkg::ST_SLEEP
                                && sleepMode_r == cpsc_pkg::MODE_PDOWN); // [RULE23]
            // Only clocks stop, so storage is held, never cleared [RULE15]
            coreAsleep_r   <= (state_nxt != cpsc_pkg::ST_RUN);
            resumeIrq_r    <= (state_r == cpsc_pkg::ST_HALT)
                              && (state_nxt == cpsc_pkg::ST_RUN); // [RULE14]
            adcAutoStart_r <= goSleep && adcEnabled
                              && (mode_r == cpsc_pkg::MODE_IDLE
                                  || mode_r == cpsc_pkg::MODE_ADCNR); // [RULE20]
        end
    end

endmodule // cpsc_clock_sleep

/* tb/cpsc_monitor.sv */
// Port checker for the clock prescaler and sleep sequencer.
// Sees the sleep and clock ports of cpsc_clock_sleep; bound at the foot.
`timescale 1ns/1ps
module cpsc_monitor (
    // Clock and reset
    input wire logic                     clk,
    input wire logic                     rst,
    // Core side
    input wire logic                     sleepInstr,
    input wire logic                     adcEnabled,
    // Clock control outputs
    input wire cpsc_pkg::cpsc_clken_type clkEn_r,
    input wire logic                     oscRun_r,
    input wire logic                     coreAsleep_r,
    input wire logic                     resumeIrq_r,
    input wire logic                     adcAutoStart_r
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////
    // Entry and exit of the sleep state
    sequence s_enter; !coreAsleep_r ##1 coreAsleep_r; endsequence
    sequence s_leave; coreAsleep_r ##1 !coreAsleep_r; endsequence

    property p_enter; s_enter |-> $past(sleepInstr); endproperty
    property p_auto; adcAutoStart_r |-> coreAsleep_r && !$past(coreAsleep_r)
        && $past(adcEnabled); endproperty
    property p_resume; s_leave |-> resumeIrq_r; endproperty
    property p_resume_src; resumeIrq_r |-> $past(coreAsleep_r); endproperty
    property p_cpu_off; coreAsleep_r && $past(coreAsleep_r) |-> !clkEn_r.cpu; endproperty
    property p_io_adc; clkEn_r.io |-> clkEn_r.adc; endproperty
    property p_cpu_flash; clkEn_r.cpu == clkEn_r.flash && (!clkEn_r.cpu || clkEn_r.io);
    endproperty
    property p_osc; !oscRun_r |-> coreAsleep_r && clkEn_r == 4'h0; endproperty
    property p_boot; $fell(rst) |-> clkEn_r == 4'h0 ##1 clkEn_r == 4'h0; endproperty
    property p_rst_wake; $fell(rst) |-> !coreAsleep_r; endproperty

    a_enter:      assert property (p_enter) else $error("sleep without instr");
    a_auto:       assert property (p_auto) else $error("bad adc start");
    a_resume:     assert property (p_resume) else $error("no resume pulse");
    a_resume_src: assert property (p_resume_src) else $error("stray resume");
    a_cpu_off:    assert property (p_cpu_off) else $error("cpu ticks asleep");
    a_io_adc:     assert property (p_io_adc) else $error("io without adc");
    a_cpu_flash:  assert property (p_cpu_flash) else $error("domains split");
    a_osc:        assert property (p_osc) else $error("osc stop awake");
    a_boot:       assert property (p_boot) else $error("clock before boot");
    a_rst_wake:   assert property (p_rst_wake) else $error("asleep after reset");
endmodule // cpsc_monitor

bind cpsc_clock_sleep cpsc_monitor u_mon (.clk(clk), .rst(rst), .sleepInstr(sleepInstr),
    .adcEnabled(adcEnabled), .clkEn_r(clkEn_r), .oscRun_r(oscRun_r),
    .coreAsleep_r(coreAsleep_r), .resumeIrq_r(resumeIrq_r), .adcAutoStart_r(adcAutoStart_r));

/* tb/test_cpsc_clock_sleep.sv */
// Self-checking bench: register tasks, divider changes, sleep modes.
// Assumes cpsc_pkg and the design top; clk 50 ns period.
`timescale 1ns/1ps
module test_cpsc_clock_sleep;
    logic                     clk, rst, regWr, regRd, fuse, sleepInstr, adcEn;
    logic [3:0]               regAddr, pins;
    logic [7:0]               regWdata, regRdata_r;
    cpsc_pkg::cpsc_irq_type   irqReq;
    cpsc_pkg::cpsc_clken_type clkEn_r;
    logic                     oscRun_r, coreAsleep_r, resumeIrq_r, adcAutoStart_r;
    int                       failCount = 0;
    int                       checks = 0;
    int                       g, f, fOld, n;
    logic [3:0]               c;
    // Per mode: code, enables asleep, wake sources, latency
    logic [2:0]               md[4] = '{3'h0, 3'h1, 3'h2, 3'h6};
    logic [3:0]               ce[4] = '{4'h3, 4'h1, 4'h0, 4'h0};
    logic [6:0]               good[4] = '{7'h40, 7'h10, 7'h00, 7'h04};
    logic [6:0]               bad[4] = '{7'h00, 7'h20, 7'h40, 7'h02};
    int                       lat[4] = '{6, 6, 1031, 11};

    cpsc_clock_sleep u_dut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata_r(regRdata_r), .startupDivideFuse(fuse),
        .externalInterruptPins(pins), .sleepInstr(sleepInstr), .adcEnabled(adcEn),
        .irqReq(irqReq), .clkEn_r(clkEn_r), .oscRun_r(oscRun_r), .coreAsleep_r(coreAsleep_r),
        .resumeIrq_r(resumeIrq_r), .adcAutoStart_r(adcAutoStart_r));

    ////////////////////////////////////////////////////////////////////////
    // Clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    // Tasks
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] got);
        checks++;
        if (got !== e) begin
            failCount++;
            $display("MISMATCH %s expected %h seen %h", nm, e, got);
        end
    endtask
    // Strobe held to the next edge, so writes chain
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
    endtask
    task automatic idle();
        @(posedge clk);
        regWr <= 1'b0;
        regRd <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        regWr <= 1'b0;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        chk("rdata", e, regRdata_r);
    endtask
    // Counts cycles up to the next cpu enable pulse; bounded
    task automatic gap(output int k);
        k = 0;
        do begin
            @(posedge clk);
            #1;
            k++;
        end while (clkEn_r.cpu !== 1'b1 && k < 600);
    endtask
    task automatic slp();
        @(posedge clk);
        sleepInstr <= 1'b1;
        @(posedge clk);
        sleepInstr <= 1'b0;
        #1;
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, failCount);
        if (failCount == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Watchdog: some 11x the run of about 3.5k cycles
    initial begin
        repeat (40000) @(posedge clk);
        failCount++;
        report_and_stop();
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {rst, fuse, adcEn} = 3'h7;
        {regWr, regRd, sleepInstr, regAddr, pins, regWdata} = '0;
        irqReq = '0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (5) @(posedge clk);
        rd(4'h0, 8'h03);
        wr(4'h0, 8'h05);
        wr(4'h0, 8'h81);
        idle();
        rd(4'h0, 8'h03);
        repeat (3) wr(4'h0, 8'h80);
        rd(4'h0, 8'h83);
        idle();
        wr(4'h0, 8'h05);
        idle();
        rd(4'h0, 8'h03);
        // Codes 9 down to 0; reserved 9 divides as 256
        fOld = 8;
        for (int i = 0; i < 10; i++) begin
            c = 4'h9 - 4'(i);
            f = (c > 4'h8) ? 256 : (1 << c);
            wr(4'h0, 8'h80);
            wr(4'h0, {4'h0, c});
            idle();
            rd(4'h0, {4'h0, c});
            gap(g);
            gap(g);
            chk("gapmin", 1, g >= ((f < fOld) ? f : fOld));
            gap(g);
            chk("divide", f, g);
            fOld = f;
        end
        // Each mode: enter, foreign source (none for Idle), wake
        for (int m = 0; m < 4; m++) begin
            wr(4'h1, {4'h0, md[m], 1'b1});
            idle();
            rd(4'h1, {4'h0, md[m], 1'b1});
            slp();
            chk("asleep", 1, coreAsleep_r);
            chk("autostart", m < 2, adcAutoStart_r);
            @(posedge clk);
            irqReq <= cpsc_pkg::cpsc_irq_type'(bad[m]);
            repeat (4) @(posedge clk);
            #1;
            chk("clken", ce[m], clkEn_r);
            chk("osc", m != 2, oscRun_r);
            chk("holds", 1, coreAsleep_r);
            @(posedge clk);
            irqReq <= cpsc_pkg::cpsc_irq_type'(good[m]);
            pins <= (m == 2) ? 4'h1 : 4'h0;
            n = 0;
            do begin
                @(posedge clk);
                #1;
                n++;
            end while (resumeIrq_r !== 1'b1 && n < 1100);
            chk("wake", lat[m], n);
            chk("awake", 0, coreAsleep_r);
            @(posedge clk);
            irqReq <= '0;
            pins <= 4'h0;
            wr(4'h1, 8'h00);
            idle();
        end
        // No sleep: enable clear, reserved mode
        for (int k = 0; k < 2; k++) begin
            wr(4'h1, (k == 0) ? 8'h00 : 8'h07);
            idle();
            slp();
            chk("nosleep", 0, coreAsleep_r);
        end
        // Reset while asleep, fuse now unprogrammed
        wr(4'h1, 8'h01);
        idle();
        slp();
        @(posedge clk);
        rst <= 1'b1;
        fuse <= 1'b0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (5) @(posedge clk);
        #1;
        chk("rstwake", 0, coreAsleep_r);
        rd(4'h0, 8'h00);
        rd(4'h1, 8'h00);
        report_and_stop();
    end
endmodule // test_cpsc_clock_sleep
